// file: pkg/crtc_pkg.sv
// Purpose: shared constants and types for the character raster timing controller
// Assumes: character-rate clock, registers written through an indirect index
// Notes: two fixed timing formats chosen by the format select pin
package crtc_pkg;
    localparam int MA_W   = 14;
    localparam int RA_W   = 5;
    localparam int IDX_W  = 5;
    localparam int PAR_W  = 8;
    localparam int SYNC_W = 4;

    // writable register indices
    localparam logic [IDX_W-1:0] IDX_START_HIGH  = 5'h0c;
    localparam logic [IDX_W-1:0] IDX_START_LOW   = 5'h0d;
    localparam logic [IDX_W-1:0] IDX_CURSOR_HIGH = 5'h0e;
    localparam logic [IDX_W-1:0] IDX_CURSOR_LOW  = 5'h0f;
    localparam int HIGH_BITS = 6;

    // skew and mode field positions
    localparam int CUR_SKEW_LSB = 6;
    localparam int DE_SKEW_LSB  = 4;
    localparam int CMODE_LSB    = 5;
    localparam logic [1:0] SKEW_NONE = 2'h0;
    localparam logic [1:0] SKEW_ONE  = 2'h1;
    localparam logic [1:0] SKEW_TWO  = 2'h2;
    localparam logic [1:0] CM_STEADY = 2'h0;
    localparam logic [1:0] CM_OFF    = 2'h1;
    localparam logic [1:0] CM_SLOW   = 2'h2;
    localparam logic [1:0] CM_FAST   = 2'h3;
    localparam logic [1:0] IL_SYNC_VIDEO = 2'h3;
    localparam int BLINK_SLOW_BIT = 3;
    localparam int BLINK_FAST_BIT = 4;
    localparam logic [4:0] VSYNC_ZERO_WIDTH = 5'h10;

    typedef struct packed {
        logic [PAR_W-1:0] h_total;
        logic [PAR_W-1:0] h_displayed;
        logic [PAR_W-1:0] hsync_pos;
        logic [PAR_W-1:0] sync_width;
        logic [6:0]       v_total;
        logic [4:0]       v_adjust;
        logic [6:0]       v_displayed;
        logic [6:0]       vsync_pos;
        logic [PAR_W-1:0] interlace_skew;
        logic [RA_W-1:0]  max_scan_line;
        logic [6:0]       cursor_start;
        logic [RA_W-1:0]  cursor_end;
    } crtc_format_t;
endpackage

// file: pkg/crtc_fmt_if.sv
// Purpose: carries the selected timing format to the controller
// Assumes: driven by the format table
// Notes: one select, one format word
`timescale 1ns/1ps
`default_nettype none
interface crtc_fmt_if;
    import crtc_pkg::*;
    logic         sel;
    crtc_format_t fmt;
    modport table_side (input sel, output fmt);
    modport user_side  (output sel, input fmt);
endinterface
`default_nettype wire

// file: src/crtc_fmt_rom.sv
// Purpose: holds the two fixed timing formats and registers the chosen one
// Assumes: select already synchronised
// Notes: values are parameters so a chip variant can change them
`timescale 1ns/1ps
`default_nettype none
module crtc_fmt_rom
    import crtc_pkg::*;
#(
    parameter crtc_format_t FMT0 = '{8'h63, 8'h50, 8'h52, 8'h2c, 7'h1f, 5'h06, 7'h19, 7'h1c,
                                     8'h00, 5'h07, 7'h06, 5'h07},
    parameter crtc_format_t FMT1 = '{8'h3f, 8'h28, 8'h2d, 8'h26, 7'h26, 5'h00, 7'h19, 7'h20,
                                     8'h50, 5'h07, 7'h46, 5'h07}
) (
    input  wire logic  core_clk_i,
    input  wire logic  reset_i,
    crtc_fmt_if.table_side port
);
    import crtc_pkg::*;
    crtc_format_t fmt_q;
    crtc_format_t next_fmt;
    always_comb begin
        next_fmt = port.sel ? FMT1 : FMT0;
    end
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fmt_q <= FMT0; // same format the reset select flops pick
        end else begin
            fmt_q <= next_fmt;
        end
    end
    assign port.fmt = fmt_q;
endmodule
`default_nettype wire

// file: src/crtc_timing_controller.sv
// Purpose: raster video timing generator with indirect write-only registers
// Assumes: core_clk_i is the character clock; bus strobes are synchronous to it
// Notes: only start and cursor addresses are writable
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - cursor output delayed zero, one or two clocks by its skew field
// - display enable delayed zero, one or two clocks by its own field
// - interlace field low bit selects interlace; 11 adds interlaced video
// - maximum scan line sets scan lines per character row
// - cursor start may be any scan line from 0 to 31
// - cursor mode: steady, suppressed, blink at 1/16 or 1/32 field rate
// - start address is six high bits plus eight low bits
// - refresh address starts at start address, wraps past 16K
// - cursor address fourteen bits, compared with refresh address
// - select low writes index from data bits 0-4, high writes indexed register
// - only start and cursor writable; other timing from fixed selected set
// - counters compared to parameters; match resets counter and or sets flag
// - horizontal counter restarts each line; total, position, width form hsync
// - display enable is horizontal enable and vertical enable
// - one horizontal pulse per line steps vertical and row counters
// - vertical counter forms vsync period, position and width
// - vertical enable spans vertical displayed rows per frame
// - vertical reset once per frame: total times rows plus adjust
// - hsync width from low four bits of sync width
// - vsync width from upper four bits, zero means sixteen
// - cursor when row in start to end and address matches cursor address
// - row reset advances first-character address by displayed count
module crtc_timing_controller
    import crtc_pkg::*;
(
    input  wire logic                      core_clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      chip_select_n_i,
    input  wire logic                      register_select_i,
    input  wire logic                      write_i,
    input  wire logic [7:0]                data_i,
    input  wire logic                      format_select_i,
    output logic [crtc_pkg::MA_W-1:0]      refresh_mem_addr_o,
    output logic [crtc_pkg::RA_W-1:0]      scan_row_addr_o,
    output logic                           hsync_o,
    output logic                           vsync_o,
    output logic                           display_enable_o,
    output logic                           cursor_o
);
    import crtc_pkg::*;

    // format pin comes from outside; two flops before use
    logic fsel_meta, fsel_sync;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fsel_meta <= 1'b0;
            fsel_sync <= 1'b0;
        end else begin
            fsel_meta <= format_select_i;
            fsel_sync <= fsel_meta;
        end
    end

    crtc_fmt_if fmt_bus();
    assign fmt_bus.sel = fsel_sync;
    crtc_fmt_rom u_rom (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .port       (fmt_bus)
    );
    crtc_format_t f;
    assign f = fmt_bus.fmt;

    // register file
    logic [IDX_W-1:0]   register_index, next_index;
    logic [MA_W-1:0]    display_start_address, next_start;
    logic [MA_W-1:0]    cursor_position_address, next_cursor;
    logic               wr;
    assign wr = !chip_select_n_i && write_i;
    always_comb begin
        next_index  = register_index;
        next_start  = display_start_address;
        next_cursor = cursor_position_address;
        if (wr && !register_select_i) begin
            next_index = data_i[IDX_W-1:0];
        end else if (wr) begin
            unique case (register_index)
                IDX_START_HIGH:  next_start[MA_W-1:8]  = data_i[HIGH_BITS-1:0];
                IDX_START_LOW:   next_start[7:0]       = data_i;
                IDX_CURSOR_HIGH: next_cursor[MA_W-1:8] = data_i[HIGH_BITS-1:0];
                IDX_CURSOR_LOW:  next_cursor[7:0]      = data_i;
                default: ; // fixed parameters ignore writes
            endcase
        end
    end
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            register_index          <= '0;
            display_start_address   <= '0;
            cursor_position_address <= '0;
        end else begin
            register_index          <= next_index;
            display_start_address   <= next_start;
            cursor_position_address <= next_cursor;
        end
    end

    // counters
    logic [PAR_W-1:0] h_cnt, next_h_cnt;
    logic [RA_W-1:0]  row_cnt, next_row_cnt;
    logic [6:0]       v_cnt, next_v_cnt;
    logic [4:0]       adj_cnt, next_adj_cnt;
    logic             in_adjust, next_in_adjust;
    logic [SYNC_W-1:0] hs_cnt, next_hs_cnt;
    logic [4:0]       vs_cnt, next_vs_cnt;
    logic             hsync, next_hsync, vsync, next_vsync;
    logic             h_de, next_h_de, v_de, next_v_de;
    logic             field, next_field;
    logic [4:0]       frame_cnt, next_frame_cnt;
    logic [MA_W-1:0]  linear_address_counter, next_lac, row_first, next_row_first;

    logic h_end, row_end, frame_end;
    logic [RA_W-1:0] row_max;
    logic [4:0] vs_width;
    logic interlace_on, il_video;
    assign interlace_on = f.interlace_skew[0];
    assign il_video = f.interlace_skew[1:0] == IL_SYNC_VIDEO;
    assign row_max = f.max_scan_line;
    assign h_end = h_cnt == f.h_total;
    assign row_end = h_end && (in_adjust ? 1'b0 : row_cnt >= row_max);
    assign frame_end = h_end && (in_adjust ? adj_cnt + 5'h01 >= f.v_adjust
                                           : (row_cnt >= row_max && v_cnt == f.v_total
                                              && f.v_adjust == 5'h00));
    assign vs_width = (f.sync_width[7:4] == 4'h0) ? VSYNC_ZERO_WIDTH
                                                  : {1'b0, f.sync_width[7:4]};

    always_comb begin
        next_h_cnt = h_end ? '0 : h_cnt + 1'b1;
        next_h_de = h_end ? 1'b1 : (next_h_cnt == f.h_displayed ? 1'b0 : h_de);
        next_hsync = hsync;
        next_hs_cnt = hs_cnt;
        if (hsync) begin
            next_hs_cnt = hs_cnt + 1'b1;
            if (hs_cnt + 1'b1 == f.sync_width[SYNC_W-1:0]) begin
                next_hsync = 1'b0;
            end
        end else if (next_h_cnt == f.hsync_pos) begin
            next_hsync = 1'b1;
            next_hs_cnt = '0;
        end
        next_row_cnt = row_cnt;
        next_v_cnt = v_cnt;
        next_adj_cnt = adj_cnt;
        next_in_adjust = in_adjust;
        next_vsync = vsync;
        next_vs_cnt = vs_cnt;
        next_v_de = v_de;
        next_field = field;
        next_frame_cnt = frame_cnt;
        next_lac = linear_address_counter + 1'b1;
        next_row_first = row_first;
        if (h_end) begin
            next_lac = row_first;
            if (frame_end) begin
                next_row_cnt = (il_video && !field) ? RA_W'(1) : '0;
                next_v_cnt = '0;
                next_adj_cnt = '0;
                next_in_adjust = 1'b0;
                next_v_de = 1'b1;
                next_field = interlace_on ? !field : 1'b0;
                next_frame_cnt = frame_cnt + 1'b1;
                next_row_first = display_start_address;
                next_lac = display_start_address;
            end else if (row_end) begin
                next_row_cnt = '0;
                next_row_first = row_first + MA_W'(f.h_displayed);
                next_lac = next_row_first;
                if (v_cnt == f.v_total) begin
                    next_in_adjust = 1'b1;
                end else begin
                    next_v_cnt = v_cnt + 1'b1;
                end
                if (v_cnt + 7'h01 == f.v_displayed) begin
                    next_v_de = 1'b0;
                end
                if (v_cnt + 7'h01 == f.vsync_pos) begin
                    next_vsync = 1'b1;
                    next_vs_cnt = '0;
                end
            end else begin
                next_row_cnt = row_cnt + ((il_video) ? RA_W'(2) : RA_W'(1));
                if (in_adjust) begin
                    next_adj_cnt = adj_cnt + 1'b1;
                end
            end
            if (vsync) begin
                next_vs_cnt = vs_cnt + 1'b1;
                if (vs_cnt + 5'h01 == vs_width) begin
                    next_vsync = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            h_cnt <= '0;
            row_cnt <= '0;
            v_cnt <= '0;
            adj_cnt <= '0;
            in_adjust <= 1'b0;
            hs_cnt <= '0;
            vs_cnt <= '0;
            hsync <= 1'b0;
            vsync <= 1'b0;
            h_de <= 1'b1;
            v_de <= 1'b1;
            field <= 1'b0;
            frame_cnt <= '0;
            linear_address_counter <= '0;
            row_first <= '0;
        end else begin
            h_cnt <= next_h_cnt;
            row_cnt <= next_row_cnt;
            v_cnt <= next_v_cnt;
            adj_cnt <= next_adj_cnt;
            in_adjust <= next_in_adjust;
            hs_cnt <= next_hs_cnt;
            vs_cnt <= next_vs_cnt;
            hsync <= next_hsync;
            vsync <= next_vsync;
            h_de <= next_h_de;
            v_de <= next_v_de;
            field <= next_field;
            frame_cnt <= next_frame_cnt;
            linear_address_counter <= next_lac;
            row_first <= next_row_first;
        end
    end

    // cursor and skew
    logic blink_on, cur_raw, de_raw;
    logic [1:0] cmode, cskew, dskew;
    logic [1:0] cur_pipe, next_cur_pipe, de_pipe, next_de_pipe;
    assign cmode = f.cursor_start[CMODE_LSB +: 2];
    assign cskew = f.interlace_skew[CUR_SKEW_LSB +: 2];
    assign dskew = f.interlace_skew[DE_SKEW_LSB +: 2];
    always_comb begin
        unique case (cmode)
            CM_STEADY: blink_on = 1'b1;
            CM_OFF:    blink_on = 1'b0;
            CM_SLOW:   blink_on = frame_cnt[BLINK_SLOW_BIT];
            CM_FAST:   blink_on = frame_cnt[BLINK_FAST_BIT];
        endcase
    end
    // start line uses full five bits, 0 to 31
    assign cur_raw = blink_on && !in_adjust && (row_cnt >= f.cursor_start[RA_W-1:0])
                     && (row_cnt <= f.cursor_end) && (linear_address_counter == cursor_position_address);
    assign de_raw = h_de && v_de;
    always_comb begin
        next_cur_pipe = {cur_pipe[0], cur_raw};
        next_de_pipe  = {de_pipe[0], de_raw};
    end
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cur_pipe <= '0;
            de_pipe <= '0;
        end else begin
            cur_pipe <= next_cur_pipe;
            de_pipe <= next_de_pipe;
        end
    end
    function automatic logic skew_pick(input logic [1:0] s, input logic [2:0] p);
        unique case (s)
            SKEW_ONE: skew_pick = p[1];
            SKEW_TWO: skew_pick = p[2];
            default:  skew_pick = p[0];
        endcase
    endfunction

    // all outputs share one stage; no-skew tap is the raw value so it lines up with ma
    logic hs_o_q, vs_o_q, de_o_q, cur_o_q;
    logic [MA_W-1:0] ma_q;
    logic [RA_W-1:0] ra_q;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ma_q    <= '0;
            ra_q    <= '0;
            hs_o_q  <= 1'b0;
            vs_o_q  <= 1'b0;
            de_o_q  <= 1'b0;
            cur_o_q <= 1'b0;
        end else begin
            ma_q    <= linear_address_counter;
            ra_q    <= row_cnt;
            hs_o_q  <= hsync;
            vs_o_q  <= vsync;
            de_o_q  <= skew_pick(dskew, {de_pipe, de_raw});
            cur_o_q <= skew_pick(cskew, {cur_pipe, cur_raw});
        end
    end
    assign refresh_mem_addr_o = ma_q;
    assign scan_row_addr_o = ra_q;
    assign hsync_o = hs_o_q;
    assign vsync_o = vs_o_q;
    assign display_enable_o = de_o_q;
    assign cursor_o = cur_o_q;

    a_hsync_width: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $rose(hsync) && f.sync_width[3:0] == 4'h6 |-> hsync [*6] ##1 !hsync)
        else $error("hsync width wrong");
    a_h_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
        h_end |=> h_cnt == 8'h00) else $error("horizontal counter did not restart");
    a_row_adv: assert property (@(posedge core_clk_i) disable iff (reset_i)
        row_end && !frame_end |=> row_first == $past(row_first) + MA_W'($past(f.h_displayed)))
        else $error("row address not advanced");
    a_frame_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
        frame_end |=> linear_address_counter == $past(display_start_address)) else $error("frame not loaded from start");
    a_lac_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !h_end |=> linear_address_counter == $past(linear_address_counter) + 14'h0001) else $error("refresh address did not step");
    a_de_and: assert property (@(posedge core_clk_i) disable iff (reset_i)
        de_raw == (h_cnt < f.h_displayed && v_de)) else $error("display enable not and");
    a_cursor_match: assert property (@(posedge core_clk_i) disable iff (reset_i)
        cur_raw |-> linear_address_counter == cursor_position_address && row_cnt <= f.cursor_end)
        else $error("cursor outside window");
    a_cur_skew: assert property (@(posedge core_clk_i) disable iff (reset_i)
        cskew == SKEW_ONE && $stable(cskew) |=> cur_o_q == $past(cur_raw, 2))
        else $error("cursor skew wrong");
    a_index_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr && !register_select_i |=> register_index == $past(data_i[4:0])) else $error("index not loaded");
    c_frame: cover property (@(posedge core_clk_i) disable iff (reset_i) frame_end);
    c_cursor: cover property (@(posedge core_clk_i) disable iff (reset_i) cursor_o);
    c_row: cover property (@(posedge core_clk_i) disable iff (reset_i) row_end);
endmodule
`default_nettype wire

// file: tb/crtc_crt_model.sv
// Purpose: monitor, refresh ram and character generator beside the controller
// Assumes: controller outputs settle between character clock edges
// Notes: per-frame totals latched on each vsync rise; the first total is partial
`timescale 1ns/1ps
`default_nettype none
module crtc_crt_model (
    input  wire logic        clk_i,
    input  wire logic        hsync_i,
    input  wire logic        vsync_i,
    input  wire logic        de_i,
    input  wire logic        cursor_i,
    input  wire logic [13:0] ma_i,
    input  wire logic [4:0]  ra_i,
    output logic             video_o,
    output var int           f_o [5]
);
    logic [4:0] seen;
    logic       vs_q = 1'b0;
    int         cnt [5] = '{default: 0};

    // ram modelled as holding its own address, one glyph bit per scan row
    assign video_o = (de_i & ma_i[ra_i[2:0]]) ^ cursor_i;
    assign seen = {cursor_i, de_i, vsync_i, hsync_i, 1'b1};

    always @(posedge clk_i) begin
        vs_q <= vsync_i;
        for (int k = 0; k < 5; k++) begin
            if (vsync_i && !vs_q) begin
                f_o[k] <= cnt[k];
                cnt[k] <= int'(seen[k]);
            end else begin
                cnt[k] <= cnt[k] + int'(seen[k]);
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the raster timing controller
// Assumes: default format tables of the rom, registers cleared by reset
// Notes: totals compared per frame, addresses at each display line start
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crtc_pkg::*;
    typedef struct packed {
        logic        fmt;
        logic [13:0] start;
        logic [13:0] cur;
        logic [31:0] cur_cyc;
    } crtc_row_t;
    // horizontal, vertical and scan line totals held minus one, as the coincidence logic resets on a match
    localparam crtc_format_t F [2] = '{
        '{8'h63, 8'h50, 8'h52, 8'h2c, 7'h1f, 5'h06, 7'h19, 7'h1c, 8'h00, 5'h07, 7'h06, 5'h07},
        '{8'h3f, 8'h28, 8'h2d, 8'h26, 7'h26, 5'h00, 7'h19, 7'h20, 8'h50, 5'h07, 7'h46, 5'h07}};
    // cursor kept past column 23 so blanking addresses never reach it; format 1 blinks, cursor cycles unchecked
    localparam crtc_row_t ROWS [2] = '{
        '{1'b0, 14'h3fb0, 14'h001e, 32'h2},
        '{1'b1, 14'h0123, 14'h0191, 32'hffffffff}};
    logic         clk = 1'b0;
    logic         reset_i;
    logic         cs_n;
    logic         rs;
    logic         we;
    logic         fmt;
    logic [7:0]   data;
    logic [13:0]  ma;
    logic [13:0]  e_st;
    logic [13:0]  e_cu;
    logic [13:0]  e_ma;
    logic [4:0]   ra;
    logic         hs;
    logic         vs;
    logic         de;
    logic         cur;
    logic         video;
    logic         vs_q = 1'b0;
    logic         de_q = 1'b0;
    logic         chk_on;
    int           fo [5];
    int           mismatches;
    int           n_tests;
    int           cycles;
    int           ln;
    crtc_format_t p;

    crtc_timing_controller i_dut (
        .core_clk_i         (clk),
        .reset_i            (reset_i),
        .chip_select_n_i    (cs_n),
        .register_select_i  (rs),
        .write_i            (we),
        .data_i             (data),
        .format_select_i    (fmt),
        .refresh_mem_addr_o (ma),
        .scan_row_addr_o    (ra),
        .hsync_o            (hs),
        .vsync_o            (vs),
        .display_enable_o   (de),
        .cursor_o           (cur)
    );

    crtc_crt_model i_crt (
        .clk_i    (clk),
        .hsync_i  (hs),
        .vsync_i  (vs),
        .de_i     (de),
        .cursor_i (cur),
        .ma_i     (ma),
        .ra_i     (ra),
        .video_o  (video),
        .f_o      (fo)
    );

    always #5 clk = ~clk;

    task automatic report_and_stop;
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, e, g);
        end
    endtask

    function automatic logic [13:0] skew(input logic [1:0] s);
        return (s == 2'h3) ? 14'h0 : {12'h0, s};
    endfunction

    task automatic wr(input logic sel, input logic [7:0] d);
        cs_n = 1'b0;
        we = 1'b1;
        rs = sel;
        data = d;
        @(posedge clk);
        #1;
    endtask

    task automatic load(input logic [13:0] st, input logic [13:0] cu);
        wr(1'b0, 8'h01);
        wr(1'b1, 8'hff);
        wr(1'b0, {3'h0, IDX_START_HIGH});
        wr(1'b1, {2'h3, st[13:8]});
        wr(1'b0, {3'h0, IDX_START_LOW});
        wr(1'b1, st[7:0]);
        wr(1'b0, {3'h0, IDX_CURSOR_HIGH});
        wr(1'b1, 8'h3f);
        wr(1'b1, {2'h0, cu[13:8]});
        wr(1'b0, {3'h0, IDX_CURSOR_LOW});
        wr(1'b1, cu[7:0]);
        cs_n = 1'b1;
        we = 1'b0;
    endtask

    task automatic wait_vs;
        @(posedge vs);
        @(posedge clk);
        #1;
    endtask

    task automatic zero_check;
        chk("outputs in reset", 32'h0, {9'h0, ma, ra, hs, vs, de, cur});
    endtask

    task automatic frame_check(input logic [31:0] cur_cyc);
        int lr;
        int fl;
        int hp;
        lr = int'(p.max_scan_line) + 1;
        fl = (int'(p.v_total) + 1) * lr + int'(p.v_adjust);
        hp = int'(p.h_total) + 1;
        chk("frame cycles", fl * hp, fo[0]);
        chk("hsync cycles", fl * int'(p.sync_width[3:0]), fo[1]);
        chk("vsync cycles", (p.sync_width[7:4] == 4'h0 ? 16 : int'(p.sync_width[7:4])) * hp, fo[2]);
        chk("display cycles", int'(p.v_displayed) * lr * int'(p.h_displayed), fo[3]);
        if (cur_cyc != 32'hffffffff) begin
            chk("cursor cycles", cur_cyc, fo[4]);
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            report_and_stop();
        end
        if (reset_i || (vs && !vs_q)) begin
            ln = 0;
        end
        if (chk_on && de && !de_q) begin
            e_ma = e_st + 14'(ln / (p.max_scan_line + 1) * p.h_displayed) + skew(p.interlace_skew[5:4]);
            chk("line address", e_ma, ma);
            ln++;
        end
        if (chk_on && cur) begin
            e_ma = e_cu + skew(p.interlace_skew[7:6]);
            chk("cursor address", e_ma, ma);
            chk("cursor row", 32'h1, {31'h0, (ra >= p.cursor_start[4:0] && ra <= p.cursor_end)});
        end
        vs_q = vs;
        de_q = de;
    end

    initial begin
        crtc_row_t r;
        reset_i = 1'b1;
        cs_n = 1'b1;
        rs = 1'b0;
        we = 1'b0;
        data = 8'h00;
        fmt = 1'b0;
        chk_on = 1'b0;
        e_st = 14'h0;
        e_cu = 14'h0;
        p = F[0];
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        ln = 0;
        repeat (8) @(posedge clk);
        #1;
        zero_check();
        reset_i = 1'b0;
        foreach (ROWS[i]) begin
            r = ROWS[i];
            // a format change mid-frame leaves one frame unjudged
            if (r.fmt !== fmt) begin
                chk_on = 1'b0;
            end
            fmt = r.fmt;
            p = F[r.fmt];
            if (!chk_on) begin
                wait_vs();
            end
            e_st = r.start;
            e_cu = r.cur;
            load(r.start, r.cur);
            chk_on = 1'b1;
            wait_vs();
            frame_check(r.cur_cyc);
        end
        reset_i = 1'b1;
        // pin low so no format change lands in the restarted frame
        fmt = 1'b0;
        p = F[0];
        #1;
        zero_check();
        e_st = 14'h0;
        e_cu = 14'h0;
        repeat (3) @(posedge clk);
        #1;
        reset_i = 1'b0;
        wait_vs();
        report_and_stop();
    end
endmodule
`default_nettype wire
